// ==== hdl/storage_module_pkg.sv ====
// Operation
// - module holds 65,536 eight-byte doublewords
// - one doubleword access takes 0.80 us
// - two banks, alternating accesses give 0.40 us
// - seven ports: four computing, three io
// - at most one requester granted per cycle
// - io requests beat computing requests
// - ties within one type grant only one
// - reads whole doubleword, writes may be bytes
// - each byte carries parity, checked per byte on stores only
package storage_module_pkg;
   localparam int PORTS = 7;
   localparam int CE_PORTS = 4;
   localparam int IO_PORTS = 3;
   localparam int IO_BASE = 4;
   localparam int ADDR_W = 24;
   localparam int DW_BYTES = 8;
   localparam int DW_WORDS = 65536;
   localparam int BANKS = 2;
   localparam int BANK_WORDS = DW_WORDS / BANKS;
   localparam int BANK_BIT = 3;
   localparam int ROW_LSB = 4;
   localparam int ROW_MSB = 18;
   localparam real REF_CLK_MHZ = 100.0;
   localparam real FULL_CYCLE_US = 0.80;
   localparam real INTERLEAVED_CYCLE_US = 0.40;
   localparam int FULL_CYCLE_CLKS = $rtoi(FULL_CYCLE_US * REF_CLK_MHZ + 0.5);
   localparam int INTERLEAVED_CYCLE_CLKS = $rtoi(INTERLEAVED_CYCLE_US * REF_CLK_MHZ + 0.5);
   localparam int CNT_W = 7;
   localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(FULL_CYCLE_CLKS);
   localparam logic ODD_PARITY = 1'b1;
endpackage : storage_module_pkg

// ==== hdl/rotating_picker.sv ====
`timescale 1ns/1ps
module rotating_picker #(
   parameter int N = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [N-1:0] req,
   input wire logic take,
   output logic [N-1:0] grant
);
   localparam int W = $clog2(N);
   logic [W-1:0] last_q;
   logic [W-1:0] pick;

   // search starts just after the last winner so no port can starve the rest
   always_comb
   begin
      int idx;
      bit found;
      idx = 0;
      found = 1'b0;
      grant = '0;
      pick = last_q;
      for (int k = 1; k <= N; k++)
      begin
         idx = (int'(last_q) + k) % N;
         if (!found && req[idx])
         begin
            grant[idx] = 1'b1;
            pick = W'(idx);
            found = 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         last_q <= W'(N - 1);
      else if (take)
         last_q <= pick;
   end
endmodule : rotating_picker

// ==== hdl/storage_module.sv ====
`timescale 1ns/1ps
module storage_module (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [6:0] reqValid,
   input wire logic [23:0] reqAddr [7],
   input wire logic [6:0] reqWrite,
   input wire logic [7:0] reqByteEn [7],
   input wire logic [63:0] reqData [7],
   input wire logic [7:0] reqParity [7],
   output logic [6:0] grant,
   output logic respValid,
   output logic [2:0] respPort,
   output logic respWrite,
   output logic [63:0] respData,
   output logic [7:0] respParity,
   output logic [7:0] parityErr,
   output logic [2:0] parityErrPort
);
   localparam int ROW_W = storage_module_pkg::ROW_MSB - storage_module_pkg::ROW_LSB + 1;

   // storage: each bank keeps data and parity per byte
   logic [63:0] memData [storage_module_pkg::BANKS][storage_module_pkg::BANK_WORDS];
   logic [7:0] memPar [storage_module_pkg::BANKS][storage_module_pkg::BANK_WORDS];

   logic [storage_module_pkg::CNT_W-1:0] bankCnt_q [2];
   logic [2:0] bankPort_q [2];
   logic bankWrite_q [2];
   logic [63:0] bankData_q [2];
   logic [7:0] bankPar_q [2];

   logic [6:0] eligible;
   logic [2:0] ioGrant;
   logic [3:0] ceGrant;
   logic ioAny;
   logic ceAny;
   logic granted;
   logic [2:0] winIdx;
   logic winBank;
   logic [ROW_W-1:0] winRow;
   logic [7:0] winBad;

   logic respValid_q;
   logic [2:0] respPort_q;
   logic respWrite_q;
   logic [63:0] respData_q;
   logic [7:0] respParity_q;
   logic [7:0] parityErr_q;
   logic [2:0] parityErrPort_q;

   // a port may compete only if the bank its address names is idle
   always_comb
   begin
      for (int i = 0; i < storage_module_pkg::PORTS; i++)
         eligible[i] = reqValid[i] && (bankCnt_q[reqAddr[i][storage_module_pkg::BANK_BIT]] == '0);
   end

   assign ioAny = |eligible[6:4];
   assign ceAny = |eligible[3:0];

   // one picker per requester type
   rotating_picker #(.N(storage_module_pkg::IO_PORTS)) ioPicker (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .req(eligible[6:4]),
      .take(ioAny),
      .grant(ioGrant)
   );

   rotating_picker #(.N(storage_module_pkg::CE_PORTS)) cePicker (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .req(eligible[3:0]),
      .take(ceAny && !ioAny),
      .grant(ceGrant)
   );

   // io side wins outright; only one grant leaves per cycle
   assign grant = ioAny ? {ioGrant, 4'h0} : {3'h0, ceGrant};
   assign granted = |grant;

   always_comb
   begin
      winIdx = 3'h0;
      for (int i = 0; i < storage_module_pkg::PORTS; i++)
      begin
         if (grant[i])
            winIdx = 3'(i);
      end
   end

   // bits above the module's own range are not decoded here
   assign winBank = reqAddr[winIdx][storage_module_pkg::BANK_BIT];
   assign winRow = reqAddr[winIdx][storage_module_pkg::ROW_MSB:storage_module_pkg::ROW_LSB];

   always_comb
   begin
      for (int k = 0; k < storage_module_pkg::DW_BYTES; k++)
         winBad[k] = (^{reqData[winIdx][k*8 +: 8], reqParity[winIdx][k]}) != storage_module_pkg::ODD_PARITY;
   end

   // each bank cycles on its own: busy for the whole read and restore
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         for (int b = 0; b < storage_module_pkg::BANKS; b++)
         begin
            bankCnt_q[b] <= '0;
            bankPort_q[b] <= 3'h0;
            bankWrite_q[b] <= 1'b0;
         end
      end
      else
      begin
         for (int b = 0; b < storage_module_pkg::BANKS; b++)
         begin
            if (granted && (winBank == b[0]))
            begin
               bankCnt_q[b] <= storage_module_pkg::CNT_FULL;
               bankPort_q[b] <= winIdx;
               bankWrite_q[b] <= reqWrite[winIdx];
            end
            else if (bankCnt_q[b] != '0)
               bankCnt_q[b] <= bankCnt_q[b] - 1'b1;
         end
      end
   end

   // array access has no reset; fetch is always the whole doubleword
   always_ff @(posedge ref_clk)
   begin
      for (int b = 0; b < storage_module_pkg::BANKS; b++)
      begin
         if (granted && (winBank == b[0]))
         begin
            bankData_q[b] <= memData[b][winRow];
            bankPar_q[b] <= memPar[b][winRow];
            if (reqWrite[winIdx])
            begin
               for (int k = 0; k < storage_module_pkg::DW_BYTES; k++)
               begin
                  if (reqByteEn[winIdx][k])
                  begin
                     memData[b][winRow][k*8 +: 8] <= reqData[winIdx][k*8 +: 8];
                     memPar[b][winRow][k] <= reqParity[winIdx][k];
                  end
               end
            end
         end
      end
   end

   // grants are a cycle apart and cycles equal, so banks never finish together
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         respValid_q <= 1'b0;
         respPort_q <= 3'h0;
         respWrite_q <= 1'b0;
         respData_q <= 64'h0;
         respParity_q <= 8'h0;
      end
      else
      begin
         respValid_q <= 1'b0;
         for (int b = 0; b < storage_module_pkg::BANKS; b++)
         begin
            if (bankCnt_q[b] == 7'h01)
            begin
               respValid_q <= 1'b1;
               respPort_q <= bankPort_q[b];
               respWrite_q <= bankWrite_q[b];
               respData_q <= bankWrite_q[b] ? 64'h0 : bankData_q[b];
               respParity_q <= bankWrite_q[b] ? 8'h0 : bankPar_q[b];
            end
         end
      end
   end

   // store data is checked byte by byte as it is taken; the store still proceeds
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         parityErr_q <= 8'h0;
         parityErrPort_q <= 3'h0;
      end
      else
      begin
         parityErr_q <= (granted && reqWrite[winIdx]) ? (winBad & reqByteEn[winIdx]) : 8'h0;
         parityErrPort_q <= winIdx;
      end
   end

   assign respValid = respValid_q;
   assign respPort = respPort_q;
   assign respWrite = respWrite_q;
   assign respData = respData_q;
   assign respParity = respParity_q;
   assign parityErr = parityErr_q;
   assign parityErrPort = parityErrPort_q;

   grant_single_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) $onehot0(grant))
      else $error("more than one port granted");

   io_first_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) (|grant[3:0]) |-> !(|eligible[6:4]))
      else $error("computing port granted over waiting io port");

   grant_asked_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) (grant & ~eligible) == 7'h00)
      else $error("grant to a port that could not be served");

   no_idle_a: assert property (
      @(posedge ref_clk) disable iff (!resetn) (|eligible) |-> granted)
      else $error("free bank left idle while requested");

   cycle_length_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      granted |-> ##81 (respValid && respPort == $past(winIdx, 81)))
      else $error("answer not at end of full storage cycle");

   bank_busy_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (granted && !winBank) |=> (bankCnt_q[0] == storage_module_pkg::CNT_FULL)
      ##79 (bankCnt_q[0] == 7'h01)
      ##1 (bankCnt_q[0] == 7'h00))
      else $error("bank busy time wrong");

   rotate_ce_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      grant[0] ##1 (eligible[1] && !ioAny) |-> grant[1])
      else $error("computing ports not rotated");

   parity_flag_a: assert property (
      @(posedge ref_clk) disable iff (!resetn)
      (granted && reqWrite[winIdx] && |(winBad & reqByteEn[winIdx]))
      |=> (parityErr != 8'h00 && parityErrPort == $past(winIdx)))
      else $error("bad store byte parity not flagged");
endmodule : storage_module

// ==== dv/requester_ports.sv ====
`timescale 1ns/1ps
module requester_ports (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [6:0] raise,
   input wire logic [6:0] grant,
   output logic [6:0] reqValid
);
   // a port asks only when its cycle needs storage, then holds until granted
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         reqValid <= '0;
      end
      else
      begin
         reqValid <= (reqValid | raise) & ~grant;
      end
   end
endmodule : requester_ports

// ==== dv/interleaved_storage_port_arbiter_test.sv ====
`timescale 1ns/1ps
module interleaved_storage_port_arbiter_test;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [6:0] raise = '0, reqWrite = '0, reqValid, grant;
   logic [23:0] reqAddr [7];
   logic [7:0] reqByteEn [7], reqParity [7];
   logic [63:0] reqData [7], respData;
   logic respValid, respWrite;
   logic [2:0] respPort, parityErrPort, pePort;
   logic [7:0] respParity, parityErr, pe;
   int miscompares = 0, checked = 0, cyc = 0, rCyc = 0;
   int gPort[$], gCyc[$];
   localparam logic [63:0] D1 = 64'h0123456789ABCDEF;
   localparam logic [63:0] D2 = 64'hFEDCBA9876543210;
   always #5 ref_clk = ~ref_clk;
   requester_ports PM (.ref_clk(ref_clk), .resetn(resetn), .raise(raise), .grant(grant),
      .reqValid(reqValid));
   storage_module DUT (.ref_clk(ref_clk), .resetn(resetn), .reqValid(reqValid),
      .reqAddr(reqAddr), .reqWrite(reqWrite), .reqByteEn(reqByteEn), .reqData(reqData),
      .reqParity(reqParity), .grant(grant), .respValid(respValid), .respPort(respPort),
      .respWrite(respWrite), .respData(respData), .respParity(respParity),
      .parityErr(parityErr), .parityErrPort(parityErrPort));
   function automatic logic [7:0] par(input logic [63:0] d);
      for (int k = 0; k < 8; k++)
         par[k] = ~^d[8*k+:8];
   endfunction : par
   task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : chk
   task automatic close_out();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (grant != 7'h00)
      begin
         chk("onehot", $onehot(grant), 1);
         gPort.push_back($clog2(grant));
         gCyc.push_back(cyc);
      end
      if (respValid === 1'b1)
         rCyc = cyc;
      if (parityErr != 8'h00)
      begin
         pe = parityErr;
         pePort = parityErrPort;
      end
      if (cyc > 3000)
      begin
         miscompares++;
         close_out();
      end
   end
   task automatic setup(input int p, input logic [23:0] a, input logic w, input logic [7:0] be,
      input logic [63:0] d, input logic [7:0] pb);
      reqAddr[p] <= a;
      reqWrite[p] <= w;
      reqByteEn[p] <= be;
      reqData[p] <= d;
      reqParity[p] <= pb;
   endtask : setup
   // one pulse of raise; the answer is fixed at 81 edges after the grant
   // ends on an edge, so the next setup lands on it by non-blocking assignment
   task automatic fire(input logic [6:0] m, input int waitCycles);
      @(posedge ref_clk);
      raise <= m;
      @(posedge ref_clk);
      raise <= '0;
      repeat (waitCycles) @(posedge ref_clk);
   endtask : fire
   task automatic store_fetch();
      pe = '0;
      setup(2, 24'h000010, 1'b1, 8'hFF, D1, par(D1));
      fire(7'h04, 90);
      chk("store latency", rCyc - gCyc[$], 81);
      chk("store flag", respWrite, 1);
      chk("store answer data", respData, 64'h0);
      chk("good parity no flag", pe, 8'h00);
      setup(2, 24'h000010, 1'b0, 8'h00, '0, '0);
      fire(7'h04, 90);
      chk("fetch latency", rCyc - gCyc[$], 81);
      chk("fetch port", respPort, 2);
      chk("fetch flag", respWrite, 0);
      chk("fetch data", respData, D1);
      chk("fetch parity", respParity, par(D1));
      $display("test store_fetch done");
   endtask : store_fetch
   task automatic byte_store();
      logic [7:0] p1;
      logic [7:0] p2;
      p1 = par(D1);
      p2 = par(D2);
      pe = '0;
      setup(5, 24'h000010, 1'b1, 8'h01, D2, par(D2) ^ 8'h01);
      fire(7'h20, 90);
      chk("parity error", pe, 8'h01);
      chk("parity error port", pePort, 5);
      setup(5, 24'h000010, 1'b0, 8'h00, '0, '0);
      fire(7'h20, 90);
      chk("byte merge", respData, {D1[63:8], D2[7:0]});
      chk("byte parity", respParity, {p1[7:1], ~p2[0]});
      $display("test byte_store done");
   endtask : byte_store
   task automatic contention();
      int exp[7] = '{6, 4, 5, 3, 0, 1, 2};
      for (int p = 0; p < 7; p++)
         setup(p, 24'h000100, 1'b0, 8'h00, '0, '0);
      gPort.delete();
      gCyc.delete();
      fire(7'h7F, 7 * 81 + 10);
      chk("grant count", gPort.size(), 7);
      for (int i = 0; i < 7 && i < gPort.size(); i++)
      begin
         chk("grant order", gPort[i], exp[i]);
         if (i > 0)
            chk("same bank spacing", gCyc[i] - gCyc[i-1], 81);
      end
      $display("test contention done");
   endtask : contention
   task automatic interleave();
      setup(0, 24'h000020, 1'b0, 8'h00, '0, '0);
      setup(1, 24'h000028, 1'b0, 8'h00, '0, '0);
      gPort.delete();
      gCyc.delete();
      fire(7'h03, 90);
      chk("bank overlap", gCyc[1] - gCyc[0], 1);
      chk("first bank port", gPort[0], 0);
      chk("second bank port", gPort[1], 1);
      $display("test interleave done");
   endtask : interleave
   initial
   begin
      foreach (reqAddr[p])
      begin
         reqAddr[p] = '0;
         reqByteEn[p] = '0;
         reqData[p] = '0;
         reqParity[p] = '0;
      end
      repeat (6) @(posedge ref_clk);
      resetn <= 1'b1;
      store_fetch();
      byte_store();
      contention();
      interleave();
      close_out();
   end
endmodule : interleaved_storage_port_arbiter_test
